// ==== logic/adcc_pkg.sv ====
/*
 Constants, types and register map of the converter control block.
 Assumes a single core clock domain and an 8-bit software register port.
*/
// What this block does
// - Pin control register holds eight bits; bit n owns pin of channel 16+n.
// - Set pin bit: output tristated, pullup and input buffer off, reads zero.
// - Converter disabled during reset or when channel field is all ones.
// - 12/10-bit modes approximate twelve bits; 8-bit mode approximates nine.
// - 10-bit mode rounds to ten bits; 8-bit mode rounds to eight, low register.
// - Result transfer completes conversion and sets the done flag.
// - Interrupt raised when done sets while done interrupt enable is high.
// - Compare enable checks each result against the compare registers, any mode.
// - Clock source: bus, bus halved, alternate, internal async; bus after reset.
// - Selected source divided by 1, 2, 4 or 8 forms converter clock.
// - Internal async clock keeps running in wait and stop modes.
// - With hardware trigger enabled, rising trigger edge starts a conversion.
// - Trigger edge during a conversion in progress is ignored.
// - Continuous mode under hardware trigger observes only the first edge.
// - Software write to status control one starts conversion unless channel off or hardware trigger enabled.
// - Continuous mode restarts after every transfer until aborted.
// - Mode field selects 12, 10 or 8 bits; either trigger works in all.
// - High read but low unread in 12/10-bit: block transfer, no done, discard.
// - Single conversion, compare false: blocking moot, converter stops.
// - Other blocked transfers start another conversion, single or continuous.
// - Clock source codes: 00 bus, 01 bus half, 10 alternate, 11 async.
// - Divide codes: 00 by one, 01 by two, 10 by four, 11 by eight.
// - Mode codes: 00 eight-bit, 01 twelve-bit, 10 ten-bit, 11 reserved.
// - Write to status control one aborts current conversion, restarts unless off or hardware trigger enabled.
package adcc_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 3;
    localparam int RAW_W = 12;
    localparam int CH_W = 5;
    localparam int PIN_N = 8;

    localparam logic [ADDR_W-1:0] OFF_SC1 = 3'h0;
    localparam logic [ADDR_W-1:0] OFF_SC2 = 3'h1;
    localparam logic [ADDR_W-1:0] OFF_CFG = 3'h2;
    localparam logic [ADDR_W-1:0] OFF_RES_H = 3'h3;
    localparam logic [ADDR_W-1:0] OFF_RES_L = 3'h4;
    localparam logic [ADDR_W-1:0] OFF_CMP_H = 3'h5;
    localparam logic [ADDR_W-1:0] OFF_CMP_L = 3'h6;
    localparam logic [ADDR_W-1:0] OFF_PIN = 3'h7;

    localparam int SC1_CH_LSB = 0;
    localparam int SC1_CONT_BIT = 5;
    localparam int SC1_DONE_INTERRUPT_ENABLE_BIT = 6;
    localparam int SC1_DONE_BIT = 7;
    localparam int SC2_TRG_BIT = 0;
    localparam int SC2_CMPE_BIT = 1;
    localparam int SC2_GT_BIT = 2;
    localparam int CFG_CLK_LSB = 0;
    localparam int CFG_MODE_LSB = 2;
    localparam int CFG_DIV_LSB = 4;

    localparam logic [CH_W-1:0] CH_OFF = 5'h1F;
    localparam logic [PIN_N-1:0] PIN_RST = 8'h00;
    localparam logic [3:0] SAMPLE_TICKS = 4'h4;
    localparam logic [3:0] MSB_12 = 4'hB;
    localparam logic [3:0] MSB_9 = 4'h8;
    localparam logic [RAW_W-1:0] ONE12 = 12'h001;
    localparam logic [RAW_W-1:0] MAX10 = 12'h3FF;
    localparam logic [RAW_W-1:0] MAX8 = 12'h0FF;
    localparam logic [2:0] DIV1_LIM = 3'h0;
    localparam logic [2:0] DIV2_LIM = 3'h1;
    localparam logic [2:0] DIV4_LIM = 3'h3;
    localparam logic [2:0] DIV8_LIM = 3'h7;

    typedef enum logic [1:0] {
        CLK_BUS = 2'b00,
        CLK_BUS_HALF = 2'b01,
        CLK_ALT = 2'b10,
        CLK_ASYNC = 2'b11
    } adcc_clk_src_type;

    typedef enum logic [1:0] {
        MODE_8 = 2'b00,
        MODE_12 = 2'b01,
        MODE_10 = 2'b10,
        MODE_RSVD = 2'b11
    } adcc_mode_type;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_SAMPLE = 2'b01,
        ST_CONVERT = 2'b10
    } adcc_state_type;

    typedef struct packed {
        logic [CH_W-1:0] chan;
        logic cont;
        logic done_interrupt_enable;
        logic hwtrg;
        logic cmpe;
        logic cmpgt;
        adcc_clk_src_type clk_src;
        adcc_mode_type mode;
        logic [1:0] div;
    } adcc_ctrl_type;

    localparam adcc_ctrl_type CTRL_RST = '{chan: CH_OFF, cont: 1'b0, done_interrupt_enable: 1'b0,
        hwtrg: 1'b0, cmpe: 1'b0, cmpgt: 1'b0, clk_src: CLK_BUS, mode: MODE_8, div: 2'b00};
endpackage

// ==== logic/adcc_conv_ctrl.sv ====
/*
 Converter control: register port, clock select and divide, trigger handling,
 successive approximation sequencing, result formatting, compare, read blocking
 and analog pin ownership for channels 16 to 23.
 Assumes all inputs are synchronous to core_clk and that the analog front end
 answers each trial code on sar_cmp_in before the next converter clock tick.
*/
module adcc_conv_ctrl
    import adcc_pkg::*;
#(
    parameter int ASYNC_DIV = 2
) (
    input wire logic core_clk, // Bus clock
    input wire logic rst, // Async reset, high
    input wire logic [ADDR_W-1:0] reg_addr, // Register address
    input wire logic [DATA_W-1:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [DATA_W-1:0] reg_rdata, // Read data, cycle after strobe
    input wire logic hw_trigger_input, // Hardware trigger
    input wire logic alternate_clock, // Alternate clock, sampled
    input wire logic stop_mode, // Stop mode request
    input wire logic sar_cmp_in, // Comparator: input at or above trial code
    output logic [RAW_W-1:0] sar_dac_code, // Trial code to front end
    output logic sar_sample, // Sampling phase
    output logic [CH_W-1:0] sar_channel, // Selected channel
    output logic converter_active, // Conversion in progress
    output logic conv_irq, // Converter interrupt
    input wire logic [PIN_N-1:0] port_oe_in, // Port output enables
    input wire logic [PIN_N-1:0] port_pullup_in, // Port pullup enables
    input wire logic [PIN_N-1:0] pad_in, // Pad input levels
    output logic [PIN_N-1:0] pad_oe, // Pad output enables
    output logic [PIN_N-1:0] pad_pullup_en, // Pad pullup enables
    output logic [PIN_N-1:0] pad_ibuf_en, // Pad input buffer enables
    output logic [PIN_N-1:0] port_rdata // Port read value
);
    adcc_ctrl_type ctrl_r;
    adcc_state_type state_r, state_nxt;
    logic [PIN_N-1:0] analog_pin_ctrl_ch16_23;
    logic [3:0] res_h_r;
    logic [DATA_W-1:0] res_l_r, cmp_l_r, rdata_r;
    logic [3:0] cmp_h_r;
    logic conversion_done_flag, irq_r, read_pend_r;
    logic [RAW_W-1:0] code_r, code_nxt;
    logic [3:0] idx_r, idx_nxt, scnt_r, scnt_nxt;
    logic half_r, alt_prev_r, trig_prev_r;
    logic [3:0] async_cnt_r;
    logic [2:0] div_cnt_r, div_lim;
    logic src_tick, converter_clock_tick;
    logic wr_sc1, cfg_write, sw_start, hw_start, kill, enabled;
    logic last_bit, blocked, cmp_ok, cmp_fail, xfer, restart, done_clr;
    logic [RAW_W-1:0] final_raw, fmt_res, cmp_val, diff, xfer_val;
    logic sample_r, active_r;
    logic [CH_W-1:0] chan_r;
    logic [PIN_N-1:0] oe_r, pu_r, ibuf_r, prd_r;

    function automatic logic [RAW_W-1:0] adcc_round(input logic [RAW_W-1:0] raw,
                                                    input adcc_mode_type m);
        logic [10:0] r10;
        logic [8:0] r8;
        logic [RAW_W-1:0] res;
        r10 = {1'b0, raw[11:2]} + {10'h000, raw[1]};
        r8 = {1'b0, raw[8:1]} + {8'h00, raw[0]};
        unique case (m)
            MODE_10: res = r10[10] ? MAX10 : {2'h0, r10[9:0]};
            MODE_8: res = r8[8] ? MAX8 : {4'h0, r8[7:0]};
            default: res = raw;
        endcase
        return res;
    endfunction

    assign enabled = ctrl_r.chan != CH_OFF;
    assign wr_sc1 = reg_wr && reg_addr == OFF_SC1;
    // Any mode change invalidates the running conversion
    assign cfg_write = reg_wr && (reg_addr == OFF_SC2 || reg_addr == OFF_CFG ||
                                  reg_addr == OFF_CMP_H || reg_addr == OFF_CMP_L);
    // Software start only when the trigger source is software
    assign sw_start = wr_sc1 && reg_wdata[SC1_CH_LSB +: CH_W] != CH_OFF && !ctrl_r.hwtrg;
    // Only an idle converter sees an edge, so continuous runs ignore later ones
    assign hw_start = ctrl_r.hwtrg && enabled && hw_trigger_input && !trig_prev_r &&
                      state_r == ST_IDLE;
    assign kill = wr_sc1 || cfg_write || !enabled ||
                  (stop_mode && ctrl_r.clk_src != CLK_ASYNC);

    always_comb begin
        unique case (ctrl_r.clk_src)
            CLK_BUS: src_tick = 1'b1;
            CLK_BUS_HALF: src_tick = half_r;
            CLK_ALT: src_tick = alternate_clock && !alt_prev_r;
            CLK_ASYNC: src_tick = async_cnt_r == 4'(ASYNC_DIV - 1);
        endcase
    end

    always_comb begin
        unique case (ctrl_r.div)
            2'b00: div_lim = DIV1_LIM;
            2'b01: div_lim = DIV2_LIM;
            2'b10: div_lim = DIV4_LIM;
            2'b11: div_lim = DIV8_LIM;
        endcase
    end

    assign converter_clock_tick = src_tick && div_cnt_r == div_lim;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            half_r <= 1'b0;
            alt_prev_r <= 1'b0;
            async_cnt_r <= '0;
            div_cnt_r <= '0;
        end else begin
            half_r <= !half_r;
            alt_prev_r <= alternate_clock;
            // Internal oscillator model runs regardless of stop
            async_cnt_r <= src_tick && ctrl_r.clk_src == CLK_ASYNC ? '0 : async_cnt_r + 4'h1;
            if (state_r == ST_IDLE || converter_clock_tick) begin
                div_cnt_r <= '0;
            end else if (src_tick) begin
                div_cnt_r <= div_cnt_r + 3'h1;
            end
        end
    end

    assign last_bit = state_r == ST_CONVERT && converter_clock_tick && idx_r == '0;
    assign final_raw = {code_r[RAW_W-1:1], code_r[0] & sar_cmp_in};
    assign fmt_res = adcc_round(final_raw, ctrl_r.mode);
    assign cmp_val = {cmp_h_r, cmp_l_r};
    assign diff = fmt_res - cmp_val;
    assign cmp_ok = ctrl_r.cmpgt ? fmt_res >= cmp_val : fmt_res < cmp_val;
    assign cmp_fail = ctrl_r.cmpe && !cmp_ok;
    assign blocked = read_pend_r && ctrl_r.mode != MODE_8;
    assign xfer = last_bit && !cmp_fail && !blocked;
    // Failed compare in single mode stops; other blocked cases run again
    assign restart = last_bit && (ctrl_r.cont || (blocked && !cmp_fail));
    assign xfer_val = ctrl_r.cmpe ? diff : fmt_res;

    always_comb begin
        state_nxt = state_r;
        code_nxt = code_r;
        idx_nxt = idx_r;
        scnt_nxt = scnt_r;
        if (sw_start) begin
            state_nxt = ST_SAMPLE;
            scnt_nxt = '0;
            code_nxt = '0;
        end else if (kill) begin
            state_nxt = ST_IDLE;
            code_nxt = '0;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (hw_start) begin
                        state_nxt = ST_SAMPLE;
                        scnt_nxt = '0;
                    end
                end
                ST_SAMPLE: begin
                    if (converter_clock_tick) begin
                        scnt_nxt = scnt_r + 4'h1;
                        if (scnt_r == SAMPLE_TICKS - 4'h1) begin
                            state_nxt = ST_CONVERT;
                            idx_nxt = ctrl_r.mode == MODE_8 ? MSB_9 : MSB_12;
                            code_nxt = ONE12 << (ctrl_r.mode == MODE_8 ? MSB_9 : MSB_12);
                        end
                    end
                end
                ST_CONVERT: begin
                    if (converter_clock_tick) begin
                        if (idx_r == '0) begin
                            state_nxt = restart ? ST_SAMPLE : ST_IDLE;
                            scnt_nxt = '0;
                            code_nxt = '0;
                        end else begin
                            code_nxt = (sar_cmp_in ? code_r : code_r & ~(ONE12 << idx_r)) |
                                       (ONE12 << (idx_r - 4'h1));
                            idx_nxt = idx_r - 4'h1;
                        end
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r <= ST_IDLE;
            code_r <= '0;
            idx_r <= '0;
            scnt_r <= '0;
            sample_r <= 1'b0;
            active_r <= 1'b0;
            chan_r <= CH_OFF;
        end else begin
            state_r <= state_nxt;
            code_r <= code_nxt;
            idx_r <= idx_nxt;
            scnt_r <= scnt_nxt;
            sample_r <= state_nxt == ST_SAMPLE;
            active_r <= state_nxt != ST_IDLE;
            chan_r <= wr_sc1 ? reg_wdata[SC1_CH_LSB +: CH_W] : ctrl_r.chan;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            trig_prev_r <= 1'b0;
        end else begin
            trig_prev_r <= hw_trigger_input;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_r <= CTRL_RST;
            cmp_h_r <= '0;
            cmp_l_r <= '0;
            analog_pin_ctrl_ch16_23 <= PIN_RST;
        end else if (reg_wr) begin
            unique case (reg_addr)
                OFF_SC1: begin
                    ctrl_r.chan <= reg_wdata[SC1_CH_LSB +: CH_W];
                    ctrl_r.cont <= reg_wdata[SC1_CONT_BIT];
                    ctrl_r.done_interrupt_enable <= reg_wdata[SC1_DONE_INTERRUPT_ENABLE_BIT];
                end
                OFF_SC2: begin
                    ctrl_r.hwtrg <= reg_wdata[SC2_TRG_BIT];
                    ctrl_r.cmpe <= reg_wdata[SC2_CMPE_BIT];
                    ctrl_r.cmpgt <= reg_wdata[SC2_GT_BIT];
                end
                OFF_CFG: begin
                    ctrl_r.clk_src <= adcc_clk_src_type'(reg_wdata[CFG_CLK_LSB +: 2]);
                    ctrl_r.mode <= adcc_mode_type'(reg_wdata[CFG_MODE_LSB +: 2]);
                    ctrl_r.div <= reg_wdata[CFG_DIV_LSB +: 2];
                end
                OFF_CMP_H: cmp_h_r <= reg_wdata[3:0];
                OFF_CMP_L: cmp_l_r <= reg_wdata;
                OFF_PIN: analog_pin_ctrl_ch16_23 <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Results keep the last good transfer across aborts
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            res_h_r <= '0;
            res_l_r <= '0;
        end else if (xfer) begin
            res_h_r <= ctrl_r.mode == MODE_8 ? 4'h0 : xfer_val[11:8];
            res_l_r <= xfer_val[7:0];
        end
    end

    assign done_clr = wr_sc1 || (reg_rd && reg_addr == OFF_RES_L);

    // Set beats clear on the same edge
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conversion_done_flag <= 1'b0;
            irq_r <= 1'b0;
        end else begin
            conversion_done_flag <= xfer || (conversion_done_flag && !done_clr);
            irq_r <= (xfer && ctrl_r.done_interrupt_enable) || (irq_r && !done_clr);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            read_pend_r <= 1'b0;
        end else if (reg_rd && reg_addr == OFF_RES_H && ctrl_r.mode != MODE_8) begin
            read_pend_r <= 1'b1;
        end else if (reg_rd && reg_addr == OFF_RES_L) begin
            read_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= '0;
        end else if (reg_rd) begin
            unique case (reg_addr)
                OFF_SC1: rdata_r <= {conversion_done_flag, ctrl_r.done_interrupt_enable, ctrl_r.cont, ctrl_r.chan};
                OFF_SC2: rdata_r <= {5'h00, ctrl_r.cmpgt, ctrl_r.cmpe, ctrl_r.hwtrg};
                OFF_CFG: rdata_r <= {2'h0, ctrl_r.div, ctrl_r.mode, ctrl_r.clk_src};
                OFF_RES_H: rdata_r <= {4'h0, res_h_r};
                OFF_RES_L: rdata_r <= res_l_r;
                OFF_CMP_H: rdata_r <= {4'h0, cmp_h_r};
                OFF_CMP_L: rdata_r <= cmp_l_r;
                OFF_PIN: rdata_r <= analog_pin_ctrl_ch16_23;
                default: rdata_r <= '0;
            endcase
        end else begin
            rdata_r <= '0;
        end
    end

    for (genvar g = 0; g < PIN_N; g++) begin : g_pin
        always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
                oe_r[g] <= 1'b0;
                pu_r[g] <= 1'b0;
                ibuf_r[g] <= 1'b1;
                prd_r[g] <= 1'b0;
            end else begin
                oe_r[g] <= port_oe_in[g] && !analog_pin_ctrl_ch16_23[g];
                pu_r[g] <= port_pullup_in[g] && !analog_pin_ctrl_ch16_23[g];
                ibuf_r[g] <= !analog_pin_ctrl_ch16_23[g];
                prd_r[g] <= pad_in[g] && !analog_pin_ctrl_ch16_23[g];
            end
        end
    end

    assign reg_rdata = rdata_r;
    assign sar_dac_code = code_r;
    assign sar_sample = sample_r;
    assign sar_channel = chan_r;
    assign converter_active = active_r;
    assign conv_irq = irq_r;
    assign pad_oe = oe_r;
    assign pad_pullup_en = pu_r;
    assign pad_ibuf_en = ibuf_r;
    assign port_rdata = prd_r;

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    sequence s_blocked_end;
        last_bit && blocked && !cmp_fail && !kill && !sw_start;
    endsequence

    sequence s_single_cmp_fail;
        last_bit && cmp_fail && !ctrl_r.cont && !kill && !sw_start;
    endsequence

    a_pin_isolate: assert property (##1 ((pad_oe | pad_pullup_en | port_rdata) & $past(analog_pin_ctrl_ch16_23)) == '0)
        else $error("isolated pin still driven or read");
    a_disabled_idle: assert property (!enabled && !sw_start |=> state_r == ST_IDLE && !converter_active)
        else $error("converter ran while disabled");
    a_done_sets: assert property (xfer |=> conversion_done_flag && res_l_r == $past(xfer_val[7:0]))
        else $error("transfer did not set done or load result");
    a_irq_raise: assert property (xfer && ctrl_r.done_interrupt_enable |=> conv_irq)
        else $error("interrupt missing after done");
    a_block_discard: assert property (s_blocked_end |=> $stable(res_l_r) && !$rose(conversion_done_flag)
        && state_r == ST_SAMPLE)
        else $error("blocked result not discarded and retried");
    a_cmp_stop: assert property (s_single_cmp_fail |=> state_r == ST_IDLE && !converter_active
        && $stable(res_l_r))
        else $error("single failed compare did not stop");
    // A mid-conversion edge must neither restart nor stall the bit walk
    a_hw_ignore: assert property (hw_trigger_input && !trig_prev_r && state_r == ST_CONVERT
        && idx_r != '0 && !kill && !sw_start |=> state_r == ST_CONVERT
        && idx_r == ($past(converter_clock_tick) ? $past(idx_r) - 4'h1 : $past(idx_r)))
        else $error("trigger edge disturbed running conversion");
    a_sw_start: assert property (sw_start |=> state_r == ST_SAMPLE && scnt_r == '0 && sar_sample)
        else $error("software write did not start conversion");
    a_cont_again: assert property (xfer && ctrl_r.cont && !kill && !sw_start |=> state_r == ST_SAMPLE)
        else $error("continuous mode did not restart");
    a_eight_low: assert property (xfer && ctrl_r.mode == MODE_8 |=> res_h_r == 4'h0)
        else $error("8-bit result reached high register");
    a_done_clear: assert property (done_clr && !xfer |=> !conversion_done_flag && !conv_irq)
        else $error("done flag or interrupt not cleared");
    a_nine_bits: assert property (state_r == ST_SAMPLE && state_nxt == ST_CONVERT && ctrl_r.mode == MODE_8
        |=> idx_r == MSB_9 && sar_dac_code == ONE12 << MSB_9)
        else $error("8-bit conversion did not start at bit eight");
    a_hw_launch: assert property (hw_start && !kill && !sw_start
        |=> state_r == ST_SAMPLE && converter_active)
        else $error("trigger edge did not start conversion");
    a_abort_keep: assert property ((wr_sc1 || cfg_write) && !xfer
        |=> $stable(res_l_r) && $stable(res_h_r))
        else $error("abort altered result registers");
    a_pin_inbuf: assert property (##1 pad_ibuf_en == ~$past(analog_pin_ctrl_ch16_23))
        else $error("input buffer not disabled for analog pin");
    a_stop_abort: assert property (stop_mode && ctrl_r.clk_src != CLK_ASYNC && !sw_start
        |=> !converter_active)
        else $error("stop did not abort conversion");
endmodule

// ==== verif/adcc_front_model.sv ====
/*
 Analog front end model: an ideal comparator against the trial code.
 Assumes the trial code settles before the next converter tick.
*/
module adcc_front_model
    import adcc_pkg::*;
(
    input wire logic core_clk, // Bus clock
    input wire logic active, // Converter busy
    input wire logic [RAW_W-1:0] dac, // Trial code
    input wire logic [RAW_W-1:0] vin, // Input level as a code
    output logic cmp // Input at or above trial
);
    timeunit 1ns;
    timeprecision 100ps;
    logic idle_r = 1'b0;
    // Outside a conversion the output wanders so nothing may rely on it
    always_ff @(posedge core_clk) idle_r <= ~idle_r;
    assign cmp = active ? (vin >= dac) : idle_r;
endmodule

// ==== verif/adcc_conv_ctrl_tb.sv ====
/*
 Self-checking bench for the converter control block.
 Assumes the front end model answers within one converter tick.
*/
module adcc_conv_ctrl_tb
    import adcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, hw_trig = 1'b0, alt_clk = 1'b0, stop = 1'b0;
    logic cmp, active, irq;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, rd_d, p, e;
    logic [RAW_W-1:0] vin = '0, dac;
    logic [PIN_N-1:0] oe_in = '0, pu_in = '0, pad_in = '0, pad_oe, pad_pu, pad_ib, port_rd;
    logic [CH_W-1:0] chan;
    logic [15:0] lfsr = 16'h0028;
    int fails = 0, checks_done = 0, n, f;
    adcc_mode_type modes[3] = '{MODE_12, MODE_10, MODE_8};
    adcc_conv_ctrl dut (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_trigger_input(hw_trig),
        .alternate_clock(alt_clk), .stop_mode(stop), .sar_cmp_in(cmp), .sar_dac_code(dac), .sar_sample(),
        .sar_channel(chan), .converter_active(active), .conv_irq(irq), .port_oe_in(oe_in),
        .port_pullup_in(pu_in), .pad_in(pad_in), .pad_oe(pad_oe), .pad_pullup_en(pad_pu),
        .pad_ibuf_en(pad_ib), .port_rdata(port_rd));
    adcc_front_model afe (.core_clk(core_clk), .active(active), .dac(dac), .vin(vin), .cmp(cmp));
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) alt_clk <= ~alt_clk;
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    function automatic logic [15:0] fmt(input adcc_mode_type m, input logic [RAW_W-1:0] v);
        logic [15:0] r;
        r = (m == MODE_10) ? (v >> 2) + v[1] : (m == MODE_8) ? (v >> 1) + v[0] : v;
        if (m == MODE_10 && r > MAX10) r = MAX10;
        if (m == MODE_8 && r > MAX8) r = MAX8;
        return r;
    endfunction
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd(input logic [ADDR_W-1:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 rd_d = reg_rdata;
        @(posedge core_clk);
    endtask
    task automatic wait_done();
        n = 0;
        rd_d = 8'h00;
        while (rd_d[SC1_DONE_BIT] !== 1'b1 && n < 600) begin
            rd(OFF_SC1);
            n++;
        end
        check(16'(n < 600), 16'h0001);
    endtask
    task automatic get_res(input adcc_mode_type m, input logic [RAW_W-1:0] v);
        logic [7:0] h;
        wait_done();
        check(irq, 1'b1);
        rd(OFF_RES_H);
        h = rd_d;
        rd(OFF_RES_L);
        check({h, rd_d}, fmt(m, v));
        check(irq, 1'b0);
    endtask
    task automatic end_test(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        #200000;
        fails++;
        finish_test();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        check(chan, CH_OFF);
        rd(OFF_PIN);
        check(rd_d, PIN_RST);
        rd(OFF_CFG);
        check(rd_d, 8'h00);
        for (int i = 0; i < 6; i++) begin
            lfsr = nxt(lfsr);
            p = (i == 0) ? 8'hFF : lfsr[12:5];
            e = ~p;
            oe_in <= lfsr[7:0];
            pu_in <= lfsr[15:8];
            pad_in <= lfsr[11:4];
            wr(OFF_PIN, p);
            rd(OFF_PIN);
            check(rd_d, p);
            check(pad_oe, lfsr[7:0] & e);
            check(pad_pu, lfsr[15:8] & e);
            check(pad_ib, e);
            check(port_rd, lfsr[11:4] & e);
        end
        end_test("pins");
        foreach (modes[i]) begin
            lfsr = nxt(lfsr);
            vin <= (modes[i] == MODE_8) ? {3'h0, lfsr[8:0]} : lfsr[11:0];
            wr(OFF_CFG, {4'h0, modes[i], 2'b00});
            wr(OFF_SC1, 8'h45);
            get_res(modes[i], vin);
        end
        check(chan, 5'h05);
        end_test("modes");
        wr(OFF_CFG, 8'h04);
        vin <= 12'h800;
        wr(OFF_CMP_H, 8'h01);
        wr(OFF_CMP_L, 8'h23);
        wr(OFF_SC2, 8'h06);
        wr(OFF_SC1, 8'h45);
        get_res(MODE_12, 12'h6DD);
        wr(OFF_CMP_H, 8'h09);
        wr(OFF_SC1, 8'h45);
        repeat (60) @(posedge core_clk);
        rd(OFF_SC1);
        check(rd_d[SC1_DONE_BIT], 1'b0);
        check(active, 1'b0);
        end_test("compare");
        lfsr = nxt(lfsr);
        vin <= lfsr[11:0];
        wr(OFF_SC2, 8'h01);
        wr(OFF_SC1, 8'h43);
        hw_trig <= 1'b1;
        repeat (6) @(posedge core_clk);
        hw_trig <= 1'b0;
        repeat (2) @(posedge core_clk);
        hw_trig <= 1'b1;
        get_res(MODE_12, vin);
        check(16'(n < 8), 16'h0001);
        repeat (40) @(posedge core_clk);
        check(active, 1'b0);
        hw_trig <= 1'b0;
        end_test("trigger");
        wr(OFF_SC2, 8'h00);
        wr(OFF_SC1, 8'h65);
        get_res(MODE_12, vin);
        get_res(MODE_12, vin);
        wr(OFF_SC1, 8'h45);
        rd(OFF_RES_H);
        repeat (40) @(posedge core_clk);
        rd(OFF_SC1);
        check(rd_d[SC1_DONE_BIT], 1'b0);
        rd(OFF_RES_L);
        get_res(MODE_12, vin);
        end_test("blocking");
        for (int k = 0; k < 16; k++) begin
            wr(OFF_CFG, {2'b00, k[3:2], MODE_12, k[1:0]});
            wr(OFF_SC1, 8'h45);
            n = 0;
            while (active === 1'b1 && n < 1000) begin
                @(posedge core_clk);
                n++;
            end
            f = ((k[1:0] == 2'b00) ? 1 : 2) << k[3:2];
            check(16'(n >= 15 * f && n <= 17 * f), 16'h0001);
        end
        end_test("clocks");
        stop <= 1'b1;
        wr(OFF_CFG, 8'h07);
        wr(OFF_SC1, 8'h45);
        get_res(MODE_12, vin);
        wr(OFF_CFG, 8'h04);
        wr(OFF_SC1, 8'h45);
        repeat (4) @(posedge core_clk);
        check(active, 1'b0);
        stop <= 1'b0;
        end_test("stop");
        wr(OFF_SC1, 8'h45);
        wr(OFF_SC1, 8'h5F);
        repeat (4) @(posedge core_clk);
        check(active, 1'b0);
        end_test("off");
        finish_test();
    end
endmodule
